// ---- hdl/gps_params.svh ----
// offsets, field positions and reset values for the gpio strap port
`ifndef GPS_PARAMS_SVH
`define GPS_PARAMS_SVH

// register byte offsets on the ahb-lite bus
`define GPS_A_DIR 8'h00
`define GPS_A_LVL 8'h04
`define GPS_A_FLAG 8'h08
`define GPS_A_STATUS 8'h0c
`define GPS_A_STRAP 8'h10
`define GPS_A_BOOT 8'h14
// decoded address bits
`define GPS_AW 8

// reset values
`define GPS_DIR_RST 8'h00
`define GPS_LVL_RST 8'h00
`define GPS_BOOT_RST 3'h0

// flag register fields
`define GPS_FLAG_SET 0
`define GPS_FLAG_CLR 1
// status word one field that loads the flag
`define GPS_STATUS_FLAG 0

// strap register fields
`define GPS_STR_BOOT_LO 0
`define GPS_STR_CLK 3
`define GPS_STR_PARPIN 4
`define GPS_STR_MUSTLOW 5
`define GPS_STR_BOOTING 6

// boot control fields
`define GPS_BOOT_DONE 0
`define GPS_BOOT_HS 1

// pin positions
`define GPS_PIN_CLK 4
`define GPS_PIN_MUX 6
`define GPS_PIN_LOW 7
// boot modes (one bit each) that use the clock strap pin as handshake
`define GPS_HS_MODES 8'hf0

// ahb encodings
`define GPS_HTRANS_NONSEQ 2'h2
`define GPS_HTRANS_SEQ 2'h3

`endif

// ---- hdl/gps_pkg.sv ----
// types shared by the gpio strap port
package gps_pkg;
   // boot progress of the port
   typedef enum logic [1:0] {
      GPS_CAPTURE,
      GPS_BOOTING,
      GPS_RUN
   } gps_boot_e;
   // boot mode as sampled from the straps
   typedef logic [2:0] gps_mode_t;
   // one port byte
   typedef logic [7:0] gps_byte_t;
endpackage : gps_pkg

// ---- hdl/gps_pin_cell.sv ----
// one port pin driver: direction, level, boot hold, handshake, off
`timescale 1ns/100ps
`default_nettype none
module gps_pin_cell (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // software settings
   input wire logic dir_out,
   input wire logic lvl,
   // boot and test overrides
   input wire logic hold_in,
   input wire logic hs_en,
   input wire logic hs_val,
   input wire logic off,
   // pin
   output logic pin_out,
   output logic pin_oe_n
);
   // pin registers, so the pin never glitches through the mux
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // RL13 hi-z in reset
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end else if (off) begin
         // RL14 test-off hi-z
         pin_oe_n <= 1'b1;
      end else if (hs_en) begin
         // RL7 boot handshake drive
         pin_out <= hs_val;
         pin_oe_n <= 1'b0;
      end else if (hold_in) begin
         // boot select strap pins stay inputs while booting
         pin_oe_n <= 1'b1;
      end else begin
         // RL1 per-pin direction
         pin_out <= lvl;
         pin_oe_n <= ~dir_out;
      end
   end
endmodule : gps_pin_cell
`default_nettype wire

// ---- hdl/gps_strap_cap.sv ----
// strap sampler: catches the board straps once after reset release
`timescale 1ns/100ps
`default_nettype none
`include "gps_params.svh"
module gps_strap_cap (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // capture strobe and pins
   input wire logic capture,
   input wire gps_pkg::gps_byte_t pins,
   // held configuration
   output gps_pkg::gps_mode_t boot_select_straps,
   output logic clock_source_select_bit,
   output logic parpin_mode,
   output logic must_low_bad
);
   import gps_pkg::*;
   // constants only under reset; the pins are read on the clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_select_straps <= `GPS_BOOT_RST;
         clock_source_select_bit <= 1'b0;
         parpin_mode <= 1'b0;
         must_low_bad <= 1'b0;
      end else if (capture) begin
         // RL5 boot select sample
         boot_select_straps <= pins[2:0];
         // RL9 low strap selects oscillator
         clock_source_select_bit <= pins[`GPS_PIN_CLK];
         // RL10 low strap selects parallel mode
         parpin_mode <= ~pins[`GPS_PIN_MUX];
         // RL4 board must hold it low
         must_low_bad <= pins[`GPS_PIN_LOW];
      end
   end
endmodule : gps_strap_cap
`default_nettype wire

// ---- hdl/gps_port.sv ----
// gpio port with reset straps, boot handshake and flag output
`timescale 1ns/100ps
`default_nettype none
`include "gps_params.svh"

// How it works
// RL1 - each pin individually input or output
// RL2 - level reads inputs, writes drive outputs
// RL3 - all pins inputs after reset
// RL4 - board holds must-low strap low at reset
// RL5 - boot select straps sampled after reset
// RL6 - boot pins released once boot finishes
// RL7 - clock strap pin drives boot handshake
// RL8 - select bit picks oscillator or external clock
// RL9 - low clock strap clears select bit
// RL10 - low mux strap enters parallel gpio mode
// RL11 - flag set, cleared, or loaded by status
// RL12 - flag forced high during reset
// RL13 - port pins hi-z during reset
// RL14 - pins and flag hi-z in test-off
// RL15 - straps captured once, held until reset
module gps_port (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // port pins, three signals each
   input wire gps_pkg::gps_byte_t port_pins_in,
   output gps_pkg::gps_byte_t port_pins_out,
   output gps_pkg::gps_byte_t port_pins_oe_n,
   // flag output pin
   output logic flag_output_pin,
   output logic flag_output_pin_oe_n,
   // debug pins selecting test-off
   input wire logic trst_n,
   input wire logic dbg_sel,
   input wire logic dbg_off_n,
   // configuration seen by the rest of the chip
   output gps_pkg::gps_mode_t boot_mode,
   output logic clock_source_select_bit,
   output logic parallel_pin_general_mode,
   output logic booting
);
   import gps_pkg::*;

   // boot progress
   gps_boot_e state_r;
   gps_boot_e state_nxt;
   // software registers
   gps_byte_t pin_direction_reg_r;
   gps_byte_t pin_level_reg_r;
   logic hs_val_r;
   logic boot_done_wr;
   // held strap values
   gps_mode_t strap_mode;
   logic strap_clk;
   logic strap_parpin;
   logic strap_bad;
   // bus pipeline
   logic wr_pend_r;
   logic [`GPS_AW-1:0] wr_addr_r;
   logic rd_pend_r;
   logic [`GPS_AW-1:0] rd_addr_r;
   logic addr_valid;
   // test-off, decoded from the debug pins
   logic off_mode;
   // handshake enable for the clock strap pin
   logic hs_active;
   // one bit per boot mode that drives the handshake
   logic [7:0] hs_modes;
   // value read back from the level register
   gps_byte_t level_view;
   // read mux result
   logic [31:0] rd_val;

   assign off_mode = ~trst_n & dbg_sel & ~dbg_off_n;

   // a valid transfer starts when hready samples high with nonseq/seq
   assign addr_valid = hsel & hready &
      ((htrans == `GPS_HTRANS_NONSEQ) | (htrans == `GPS_HTRANS_SEQ));

   // boot progress, next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         // one cycle to catch straps after release
         GPS_CAPTURE: state_nxt = GPS_BOOTING;
         // RL6 boot end releases pins
         GPS_BOOTING: begin
            if (boot_done_wr) begin
               state_nxt = GPS_RUN;
            end
         end
         // RL15 straps stay fixed now
         GPS_RUN: state_nxt = GPS_RUN;
         default: state_nxt = GPS_CAPTURE;
      endcase
   end

   // boot progress register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= GPS_CAPTURE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // RL15 single capture at release
   gps_strap_cap u_straps (
      .clk(clk),
      .arst_n(arst_n),
      .capture(state_r == GPS_CAPTURE),
      .pins(port_pins_in),
      .boot_select_straps(strap_mode),
      .clock_source_select_bit(strap_clk),
      .parpin_mode(strap_parpin),
      .must_low_bad(strap_bad)
   );

   // RL7 handshake only in listed modes
   assign hs_modes = `GPS_HS_MODES;
   assign hs_active = (state_r == GPS_BOOTING) & hs_modes[strap_mode];

   // write side of the bus: address phase is remembered for data phase
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= addr_valid & hwrite;
         wr_addr_r <= haddr[`GPS_AW-1:0];
      end
   end

   // a write to the boot register with the done bit set ends the boot
   assign boot_done_wr = wr_pend_r & (wr_addr_r == `GPS_A_BOOT) &
      hwdata[`GPS_BOOT_DONE];

   // direction register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // RL3 all inputs at reset
         pin_direction_reg_r <= `GPS_DIR_RST;
      end else if (wr_pend_r & (wr_addr_r == `GPS_A_DIR)) begin
         // RL1 one bit per pin
         pin_direction_reg_r <= hwdata[7:0];
      end
   end

   // level register, only output pins take effect
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_level_reg_r <= `GPS_LVL_RST;
      end else if (wr_pend_r & (wr_addr_r == `GPS_A_LVL)) begin
         // RL2 write sets driven levels
         pin_level_reg_r <= hwdata[7:0];
      end
   end

   // handshake level, written by the boot loader
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hs_val_r <= 1'b0;
      end else if (wr_pend_r & (wr_addr_r == `GPS_A_BOOT)) begin
         hs_val_r <= hwdata[`GPS_BOOT_HS];
      end
   end

   // flag pin: set wins if software asks for both in one write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // RL12 flag high in reset
         flag_output_pin <= 1'b1;
      end else if (wr_pend_r & (wr_addr_r == `GPS_A_FLAG) &
                   hwdata[`GPS_FLAG_SET]) begin
         // RL11 set-bit latch high
         flag_output_pin <= 1'b1;
      end else if (wr_pend_r & (wr_addr_r == `GPS_A_FLAG) &
                   hwdata[`GPS_FLAG_CLR]) begin
         // RL11 clear-bit latch low
         flag_output_pin <= 1'b0;
      end else if (wr_pend_r & (wr_addr_r == `GPS_A_STATUS)) begin
         // RL11 status word load
         flag_output_pin <= hwdata[`GPS_STATUS_FLAG];
      end
   end

   // flag driver enable; driven in reset so the high is seen
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_output_pin_oe_n <= 1'b0;
      end else begin
         // RL14 flag hi-z in test-off
         flag_output_pin_oe_n <= off_mode;
      end
   end

   // pin drivers, one cell each
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pin
         gps_pin_cell u_cell (
            .clk(clk),
            .arst_n(arst_n),
            .dir_out(pin_direction_reg_r[gi]),
            .lvl(pin_level_reg_r[gi]),
            // RL6 boot pins held until done
            .hold_in((gi < 3) && (state_r != GPS_RUN)),
            // RL7 only the clock strap pin
            .hs_en((gi == `GPS_PIN_CLK) && hs_active),
            .hs_val(hs_val_r),
            .off(off_mode),
            .pin_out(port_pins_out[gi]),
            .pin_oe_n(port_pins_oe_n[gi])
         );
      end
   endgenerate

   // RL2 inputs read pins, outputs read level
   assign level_view = (port_pins_in & ~pin_direction_reg_r) |
      (pin_level_reg_r & pin_direction_reg_r);

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_val = '0;
      case (rd_addr_r)
         `GPS_A_DIR: rd_val[7:0] = pin_direction_reg_r;
         `GPS_A_LVL: rd_val[7:0] = level_view;
         `GPS_A_FLAG: rd_val[`GPS_FLAG_SET] = flag_output_pin;
         `GPS_A_STATUS: rd_val[`GPS_STATUS_FLAG] = flag_output_pin;
         `GPS_A_STRAP: begin
            rd_val[`GPS_STR_BOOT_LO +: 3] = strap_mode;
            rd_val[`GPS_STR_CLK] = strap_clk;
            rd_val[`GPS_STR_PARPIN] = strap_parpin;
            rd_val[`GPS_STR_MUSTLOW] = strap_bad;
            rd_val[`GPS_STR_BOOTING] = (state_r != GPS_RUN);
         end
         `GPS_A_BOOT: begin
            rd_val[`GPS_BOOT_DONE] = (state_r == GPS_RUN);
            rd_val[`GPS_BOOT_HS] = hs_val_r;
         end
         // other offsets answer okay with zero
         default: rd_val = '0;
      endcase
   end

   // reads take one wait state, so a write just before is visible
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= '0;
         hreadyout <= 1'b1;
         hrdata <= '0;
      end else if (rd_pend_r) begin
         // second data cycle: present data, release the bus
         rd_pend_r <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= rd_val;
      end else if (addr_valid & ~hwrite) begin
         // address phase of a read: stall one cycle
         rd_pend_r <= 1'b1;
         rd_addr_r <= haddr[`GPS_AW-1:0];
         hreadyout <= 1'b0;
      end
   end

   // response is always okay
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // configuration outputs, registered
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_mode <= `GPS_BOOT_RST;
         clock_source_select_bit <= 1'b0;
         parallel_pin_general_mode <= 1'b0;
         booting <= 1'b0;
      end else begin
         // RL5 boot mode from straps
         boot_mode <= strap_mode;
         // RL8 clock source select
         clock_source_select_bit <= strap_clk;
         // RL10 parallel mode disables memory and host ports
         parallel_pin_general_mode <= strap_parpin;
         booting <= (state_nxt == GPS_BOOTING);
      end
   end
endmodule : gps_port
`default_nettype wire

// ---- dv/gps_port_properties.sv ----
// checker for the gpio strap port, bound to its ports
`timescale 1ns/100ps
`default_nettype none
module gps_port_properties (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // pins and debug
   input wire gps_pkg::gps_byte_t port_pins_in,
   input wire gps_pkg::gps_byte_t port_pins_out,
   input wire gps_pkg::gps_byte_t port_pins_oe_n,
   input wire logic flag_output_pin,
   input wire logic flag_output_pin_oe_n,
   input wire logic trst_n,
   input wire logic dbg_sel,
   input wire logic dbg_off_n,
   // configuration
   input wire gps_pkg::gps_mode_t boot_mode,
   input wire logic clock_source_select_bit,
   input wire logic parallel_pin_general_mode,
   input wire logic booting
);
   import gps_pkg::*;
   logic [2:0] since_r; // edges since release, saturates
   // count edges so strap checks know when config is settled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) since_r <= 3'h0;
      else if (since_r != 3'h7) since_r <= since_r + 3'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_reset_inputs: assert property (
      since_r == 3'h0 |-> port_pins_oe_n == 8'hff)
      else $error("pins not inputs after reset");
   chk_flag_reset: assert property (
      $rose(arst_n) |-> flag_output_pin && !flag_output_pin_oe_n)
      else $error("flag not high at reset");
   chk_boot_sample: assert property (
      since_r == 3'h3 |-> boot_mode == $past(port_pins_in[2:0], 3))
      else $error("boot mode not from straps");
   chk_clk_strap: assert property (
      since_r == 3'h3 |->
      clock_source_select_bit == $past(port_pins_in[4], 3))
      else $error("clock select not from strap");
   chk_mux_strap: assert property (
      since_r == 3'h3 |->
      parallel_pin_general_mode == !$past(port_pins_in[6], 3))
      else $error("pin mode not from strap");
   chk_cfg_held: assert property (
      since_r >= 3'h4 |-> $stable(boot_mode)
      && $stable(clock_source_select_bit)
      && $stable(parallel_pin_general_mode))
      else $error("configuration changed");
   chk_boot_hold: assert property (
      booting |-> port_pins_oe_n[2:0] == 3'h7)
      else $error("boot pins driven while booting");
   chk_hs_drive: assert property (
      booting && $past(booting, 2) && boot_mode[2]
      |-> !port_pins_oe_n[4])
      else $error("handshake pin not driven");
   chk_test_off: assert property (
      !trst_n && dbg_sel && !dbg_off_n
      |=> port_pins_oe_n == 8'hff && flag_output_pin_oe_n)
      else $error("pins not off in test-off");
   chk_read_wait: assert property (
      hsel && hready && htrans[1] && !hwrite
      |=> !hreadyout ##1 (hreadyout && !hresp))
      else $error("read handshake wrong");
   cover property (booting && boot_mode[2]);
   cover property (!trst_n && dbg_sel && !dbg_off_n);
   cover property (since_r == 3'h3 && parallel_pin_general_mode);
endmodule : gps_port_properties
bind gps_port gps_port_properties u_chk (.clk, .arst_n, .hsel,
   .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
   .hreadyout, .hresp, .port_pins_in, .port_pins_out,
   .port_pins_oe_n, .flag_output_pin, .flag_output_pin_oe_n,
   .trst_n, .dbg_sel, .dbg_off_n, .boot_mode, .clock_source_select_bit,
   .parallel_pin_general_mode, .booting);
`default_nettype wire

// ---- dv/gps_board.sv ----
// board model: strap resistors and an external driver on the pins
`timescale 1ns/100ps
`default_nettype none
module gps_board (
   // strap levels and external part
   input wire gps_pkg::gps_byte_t straps,
   input wire gps_pkg::gps_byte_t ext_val,
   input wire gps_pkg::gps_byte_t ext_en,
   // port side
   input wire gps_pkg::gps_byte_t pins_out,
   input wire gps_pkg::gps_byte_t pins_oe_n,
   output gps_pkg::gps_byte_t pins_level
);
   import gps_pkg::*;
   gps_byte_t pull; // resistor levels seen on undriven pins
   assign pull = {1'b0, straps[6:0]};
   // port drive wins, then external part, else the resistor
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pins_oe_n[i]) pins_level[i] = pins_out[i];
         else if (ext_en[i]) pins_level[i] = ext_val[i];
         else pins_level[i] = pull[i];
      end
   end
endmodule : gps_board
`default_nettype wire

// ---- dv/tb.sv ----
// testbench for the gpio strap port
`timescale 1ns/100ps
`default_nettype none
`include "gps_params.svh"
module tb;
   import gps_pkg::*;
   logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   gps_byte_t port_pins_in, port_pins_out, port_pins_oe_n;
   gps_byte_t straps, ext_val, ext_en;
   logic flag_output_pin, flag_output_pin_oe_n, trst_n, dbg_sel;
   logic dbg_off_n, clock_source_select_bit;
   logic parallel_pin_general_mode, booting;
   gps_mode_t boot_mode;
   int mismatches, checked;
   assign hready = hreadyout; // single slave
   gps_port u_dut (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
      .port_pins_in, .port_pins_out, .port_pins_oe_n,
      .flag_output_pin, .flag_output_pin_oe_n, .trst_n, .dbg_sel,
      .dbg_off_n, .boot_mode, .clock_source_select_bit,
      .parallel_pin_general_mode, .booting);
   gps_board u_board (.straps(straps), .ext_val(ext_val),
      .ext_en(ext_en), .pins_out(port_pins_out),
      .pins_oe_n(port_pins_oe_n), .pins_level(port_pins_in));
   // 40 mhz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // single transfer; waits on hready in both phases
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= `GPS_HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic t_strap();
      wt(4);
      cmp(boot_mode, 3'h5);
      cmp(clock_source_select_bit, 1'b1);
      cmp(parallel_pin_general_mode, 1'b1);
      cmp(port_pins_oe_n[4], 1'b0);
      bus(1'b0, `GPS_A_STRAP, 0);
      cmp(rd, 32'h5d);
      bus(1'b1, `GPS_A_BOOT, 32'h2);
      wt(2);
      cmp(port_pins_out[4], 1'b1);
      bus(1'b0, `GPS_A_BOOT, 0);
      cmp(rd, 32'h2);
      $display("strap test done");
   endtask : t_strap
   task automatic t_boot();
      bus(1'b1, `GPS_A_DIR, 32'hff);
      wt(2);
      cmp(port_pins_oe_n, 8'h07);
      bus(1'b1, `GPS_A_BOOT, 32'h1);
      wt(2);
      cmp(booting, 1'b0);
      cmp(port_pins_oe_n, 8'h00);
      bus(1'b0, `GPS_A_STRAP, 0);
      cmp(rd, 32'h1d);
      bus(1'b0, `GPS_A_BOOT, 0);
      cmp(rd, 32'h1);
      $display("boot test done");
   endtask : t_boot
   task automatic t_port();
      ext_en <= 8'hf0;
      ext_val <= 8'h90;
      bus(1'b1, `GPS_A_DIR, 32'h0f);
      bus(1'b1, `GPS_A_LVL, 32'ha5);
      wt(2);
      cmp(port_pins_oe_n, 8'hf0);
      cmp(port_pins_out[3:0], 4'h5);
      bus(1'b0, `GPS_A_LVL, 0);
      cmp(rd, 32'h95);
      $display("port test done");
   endtask : t_port
   task automatic t_flag();
      logic [7:0] a [6];
      logic [1:0] d [6];
      logic e [6];
      a = '{`GPS_A_FLAG, `GPS_A_FLAG, `GPS_A_FLAG, `GPS_A_STATUS,
            `GPS_A_STATUS, `GPS_A_FLAG};
      d = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h1, 2'h2};
      e = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, a[i], {30'h0, d[i]});
         wt(2);
         cmp(flag_output_pin, e[i]);
         bus(1'b0, a[i], 0);
         cmp(rd[0], e[i]);
      end
      $display("flag test done");
   endtask : t_flag
   task automatic t_off();
      trst_n <= 1'b0;
      dbg_sel <= 1'b1;
      dbg_off_n <= 1'b0;
      wt(2);
      cmp(port_pins_oe_n, 8'hff);
      cmp(flag_output_pin_oe_n, 1'b1);
      trst_n <= 1'b1;
      wt(2);
      cmp(port_pins_oe_n, 8'hf0);
      $display("test-off done");
   endtask : t_off
   task automatic t_rereset();
      arst_n <= 1'b0;
      ext_en <= 8'h00;
      straps <= 8'h42;
      #1;
      cmp(port_pins_oe_n, 8'hff);
      cmp(flag_output_pin, 1'b1);
      wt(5);
      arst_n <= 1'b1;
      wt(4);
      cmp(clock_source_select_bit, 1'b0);
      cmp(parallel_pin_general_mode, 1'b0);
      cmp(port_pins_oe_n, 8'hff);
      bus(1'b0, `GPS_A_DIR, 0);
      cmp(rd, 32'h0);
      bus(1'b0, `GPS_A_STRAP, 0);
      cmp(rd, 32'h42);
      bus(1'b0, 8'h20, 0);
      cmp(rd, 32'h0);
      $display("second reset test done");
   endtask : t_rereset
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   // watchdog: whole run is about a hundred cycles
   initial begin
      #50000;
      mismatches++;
      $display("watchdog expired at %0t", $time);
      finish_test();
   end
   initial begin
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      trst_n = 1'b1;
      dbg_sel = 1'b0;
      dbg_off_n = 1'b1;
      ext_val = 8'h00;
      ext_en = 8'h00;
      straps = 8'h15;
      mismatches = 0;
      checked = 0;
      wt(5);
      arst_n <= 1'b1;
      t_strap();
      t_boot();
      t_port();
      t_flag();
      t_off();
      t_rereset();
      finish_test();
   end
endmodule : tb
`default_nettype wire
